// [dv/dmc_host_model.sv]
// two-wire host model: makes the serial clock, drives data open-drain
// assumes pclk from the bench; the data wire has a pull-up
`timescale 1ns/1ps
`default_nettype none
module dmc_host_model
(
   input  wire logic pclk,
   input  wire logic sda_oe_n,
   output logic      scl,
   output logic      sda_wire
);
   logic host_low = 1'b0;
   logic scl_q    = 1'b1;
   assign scl = scl_q;
   // pull-up: the wire is low while either party pulls it
   assign sda_wire = !(host_low || !sda_oe_n);
   task automatic tk(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one scl period entered in the low phase; v high releases the line
   task automatic cbit(input logic v, output logic s);
      tk(2);
      host_low <= !v;
      tk(2);
      scl_q <= 1'b1;
      tk(4);
      s = sda_wire;
      scl_q <= 1'b0;
   endtask
   // also serves as repeated start
   task automatic hstart();
      tk(2);
      host_low <= 1'b0;
      tk(2);
      scl_q <= 1'b1;
      tk(4);
      host_low <= 1'b1;
      tk(4);
      scl_q <= 1'b0;
   endtask
   task automatic hstop();
      tk(2);
      host_low <= 1'b1;
      tk(2);
      scl_q <= 1'b1;
      tk(4);
      host_low <= 1'b0;
      tk(4);
   endtask
   task automatic hwr(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) cbit(b[i], s);
      cbit(1'b1, s);
      ack = !s;
   endtask
   task automatic hrd(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) cbit(1'b1, b[i]);
      cbit(nack, s);
   endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench: apb master, two-wire host model, status pins
// assumes dmc_pkg and the host model are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dmc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, rx_sig, laser_off;
   logic [7:0]  paddr, b0, b1;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, irq, scl, sda_wire, sda_oe_n, err, ack;
   logic        laser_on, lost, fault;
   dmc_mon_t    mon;
   int          n_mismatch, cmp_count, cycles;

   dmc_mgmt_link dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .scl(scl), .sda_in(sda_wire), .sda_out(),
      .sda_oe_n(sda_oe_n), .mon_raw(mon), .rx_signal_present(rx_sig),
      .laser_off_input(laser_off), .laser_on(laser_on), .signal_lost_output(lost),
      .laser_fault_output(fault));
   dmc_host_model host (.pclk(pclk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_wire(sda_wire));

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic end_sim();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // the whole run is near 7000 cycles
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      if (n == 20) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic sptr(input logic [6:0] dev, input logic [7:0] p);
      host.hstart();
      host.hwr({dev, 1'b0}, ack);
      chk(ack, 1);
      host.hwr(p, ack);
   endtask

   // every read takes two bytes, so each one is sequential
   task automatic sget(input logic [6:0] dev, input logic [7:0] p);
      sptr(dev, p);
      host.hstart();
      host.hwr({dev, 1'b1}, ack);
      host.hrd(1'b0, b0);
      host.hrd(1'b1, b1);
      host.hstop();
   endtask

   task automatic sput(input logic [6:0] dev, input logic [7:0] p, d0, d1);
      sptr(dev, p);
      host.hwr(d0, ack);
      host.hwr(d1, ack);
      host.hstop();
   endtask

   task automatic t_regs();
      apb(0, DMC_REG_CTRL, 0);
      chk(rd, 1);
      apb(0, DMC_REG_MASK, 0);
      chk(rd, 0);
      apb(1, 8'h40, 32'hFFFF_FFFF);
      chk(err, 1);
      apb(0, 8'h40, 0);
      chk(err, 1);
      chk(rd, 0);
   endtask

   task automatic t_id();
      apb(1, DMC_REG_CTRL, 0);
      apb(1, DMC_REG_IDWR, 32'h0000_05A5);
      sget(DMC_ID_ADDR, 8'h05);
      chk(b0, 8'hA5);
      // pointer wraps from the last byte of the map to the first
      sput(DMC_ID_ADDR, 8'hFF, 8'h5A, 8'h3C);
      sget(DMC_ID_ADDR, 8'hFF);
      chk({b0, b1}, 16'h5A3C);
      apb(1, DMC_REG_CTRL, 1);
      sput(DMC_ID_ADDR, 8'hFF, 8'h11, 8'h22);
      sget(DMC_ID_ADDR, 8'hFF);
      chk({b0, b1}, 16'h5A3C);
   endtask

   task automatic t_diag();
      for (int i = 0; i < DMC_NCH; i++) apb(1, DMC_REG_OFFS0 + 8'(4 * i), 32'(i == 0));
      sptr(DMC_DIAG_ADDR, 8'h00);
      for (int c = 0; c < DMC_NCH; c++)
         for (int k = 0; k < 8; k++)
            host.hwr((c == DMC_CH_BIAS && k < 2) ? {7'h00, k == 0} :
               ((k % 4 < 2) ? 8'hFF : 8'h00), ack);
      host.hstop();
      apb(0, DMC_REG_STAT, 0);
      apb(1, DMC_REG_MASK, 1);
      mon.bias <= 16'h0200;
      repeat (6) @(posedge pclk);
      chk({irq, fault}, 2'b11);
      sget(DMC_DIAG_ADDR, DMC_LIVE_BASE);
      chk({b0, b1}, 16'h1235);
      sget(DMC_DIAG_ADDR, DMC_ALM_BYTE0);
      chk({b0, b1}, 16'h0800);
      apb(0, DMC_REG_STAT, 0);
      chk(rd, 32'h09);
      apb(0, DMC_REG_STAT, 0);
      chk(rd, 0);
      chk(irq, 0);
      sput(DMC_DIAG_ADDR, DMC_LIVE_BASE, 8'h00, 8'h00);
      sget(DMC_DIAG_ADDR, DMC_LIVE_BASE);
      chk({b0, b1}, 16'h1235);
      sget(DMC_ID_ADDR, 8'h05);
      chk(b0, 8'hA5);
   endtask

   task automatic t_pins();
      int n;
      laser_off <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(laser_on, 1);
      laser_off <= 1'b1;
      for (n = 0; n < DMC_TXDIS_MAX_CYC && laser_on !== 1'b0; n++) @(posedge pclk);
      chk(laser_on, 0);
      rx_sig <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(lost, 1);
      rx_sig <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(lost, 0);
   endtask

   task automatic t_noack();
      host.hstart();
      host.hwr({7'h52, 1'b0}, ack);
      host.hstop();
      chk(ack, 0);
   endtask

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {n_mismatch, cmp_count, cycles} = '0;
      rx_sig = 1'b1;
      laser_off = 1'b1;
      mon = '{temp:16'h1234, vcc:16'h8000, bias:16'h0000, txp:16'h0050, rxp:16'h0060};
      repeat (4) @(posedge pclk);
      chk({laser_on, sda_oe_n, fault, irq}, 4'b0100);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      chk({laser_on, lost}, 2'b00);
      t_regs();
      t_id();
      t_diag();
      t_pins();
      t_noack();
      end_sim();
   end
endmodule
`default_nettype wire

// [hw/dmc_mgmt_link.sv]
// management link of an optical module: two-wire slave with id and diag maps,
// live monitor values, threshold flags, laser control pins and an apb window.
// assumes scl/sda and status pins are asynchronous to pclk; monitor samples
// arrive already synchronous on pclk.
// Contract
// R1 - id map of 256 bytes answers at seven-bit address 1010000
// R2 - diag map answers at 1010001, id map untouched
// R3 - id map returns capability and maker bytes loaded by software
// R4 - host makes the serial clock, module never drives it
// R5 - sample data on rising clock, store only into unprotected bytes
// R6 - module changes its driven data after the falling clock edge
// R7 - data line bidirectional: host sends address and data, module acks/reads
// R8 - host frames transfers with start and stop while clock is high
// R9 - maps are bytes, single or sequential access per transfer
// R10 - temperature, bias, tx power, rx power, supply readable live
// R11 - alarm and warning flags set when a value leaves its range
// R12 - diag values are calibrated inside the module by default; offsets reset to zero, so samples pass uncorrected until software loads them
// R13 - loss-of-signal output low when signal present, high when absent
// R14 - laser off within 10 us of disable input asserting
// R15 - laser off while disable input high, on only when low
// R16 - fault output high when bias or tx power over high alarm
// R17 - word pointer advances by one after every data byte
// R18 - addresses other than the two maps get no answer
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dmc_mgmt_link
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq,
   input  wire logic              scl,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe_n,
   input  wire dmc_pkg::dmc_mon_t mon_raw,
   input  wire logic              rx_signal_present,
   input  wire logic              laser_off_input,
   output logic                   laser_on,
   output logic                   signal_lost_output,
   output logic                   laser_fault_output
);
   import dmc_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_AACK, S_WADR, S_WACK, S_WDAT, S_DACK, S_RDAT, S_MACK
   } dmc_state_t;

   dmc_state_t  st;
   logic [7:0]  id_mem   [256];
   logic [7:0]  diag_mem [256];
   logic [15:0] raw      [DMC_NCH];
   logic [15:0] offs     [DMC_NCH];
   logic [15:0] live     [DMC_NCH];
   logic [3:0]  flg      [DMC_NCH];
   logic        scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   logic        laser_off_input_s1, laser_off_input_s2, sig_s1, sig_s2;
   logic        scl_rise, scl_fall, start_c, stop_c;
   logic [3:0]  bitcnt;
   logic [7:0]  sh, tx, ptr;
   logic        map_diag, rw, sel_ok;
   logic        wp_id;
   logic [4:0]  status, mask, ev, ev_d;
   logic [9:0]  alm, wrn;
   logic        apb_do, apb_wr, apb_rd;

   assign raw[0] = mon_raw.temp;
   assign raw[1] = mon_raw.vcc;
   assign raw[2] = mon_raw.bias;
   assign raw[3] = mon_raw.txp;
   assign raw[4] = mon_raw.rxp;

   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         {scl_s1, scl_s2, scl_d} <= 3'h7;
         {sda_s1, sda_s2, sda_d} <= 3'h7;
         {laser_off_input_s1, laser_off_input_s2}      <= 2'h3;
         {sig_s1, sig_s2}        <= 2'h0;
      end
      else
      begin
         scl_s1  <= scl;                                   // R4
         scl_s2  <= scl_s1;
         scl_d   <= scl_s2;
         sda_s1  <= sda_in;
         sda_s2  <= sda_s1;
         sda_d   <= sda_s2;
         laser_off_input_s1 <= laser_off_input;
         laser_off_input_s2 <= laser_off_input_s1;
         sig_s1  <= rx_signal_present;
         sig_s2  <= sig_s1;
      end

   assign scl_rise = scl_s2 & ~scl_d;
   assign scl_fall = ~scl_s2 & scl_d;
   assign start_c  = scl_s2 & scl_d & sda_d & ~sda_s2;     // R8
   assign stop_c   = scl_s2 & scl_d & ~sda_d & sda_s2;     // R8

   // live byte overlay for the diag map
   function automatic logic [7:0] rd_byte(input logic diag, input logic [7:0] a);
      logic [7:0] rel;
      rel = a - DMC_LIVE_BASE;
      if (!diag)
         rd_byte = id_mem[a];                              // R3
      else if (a == DMC_ALM_BYTE0)
         rd_byte = alm[9:2];                               // R11
      else if (a == DMC_ALM_BYTE1)
         rd_byte = {alm[1:0], 6'h00};
      else if (a == DMC_WRN_BYTE0)
         rd_byte = wrn[9:2];
      else if (a == DMC_WRN_BYTE1)
         rd_byte = {wrn[1:0], 6'h00};
      else if (a >= DMC_LIVE_BASE && rel < 8'(2 * DMC_NCH))
         rd_byte = rel[0] ? live[rel[3:1]][7:0] : live[rel[3:1]][15:8]; // R10
      else
         rd_byte = diag_mem[a];
   endfunction

   function automatic logic wr_ok(input logic diag, input logic [7:0] a, input logic wp);
      wr_ok = diag ? !(a >= DMC_LIVE_BASE && a <= DMC_LIVE_TOP) : !wp;
   endfunction

   // two-wire slave
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         st       <= S_IDLE;
         bitcnt   <= 4'h0;
         sh       <= 8'h00;
         tx       <= 8'h00;
         ptr      <= 8'h00;
         map_diag <= 1'b0;
         rw       <= 1'b0;
         sel_ok   <= 1'b0;
         sda_oe_n <= 1'b1;
      end
      else if (start_c)
      begin
         st       <= S_ADDR;
         bitcnt   <= 4'h0;
         sel_ok   <= 1'b0;
         sda_oe_n <= 1'b1;
      end
      else if (stop_c)
      begin
         st       <= S_IDLE;
         sel_ok   <= 1'b0;
         sda_oe_n <= 1'b1;
      end
      else if (scl_rise)
      begin
         case (st)
            S_ADDR, S_WADR, S_WDAT:
            begin
               sh     <= {sh[6:0], sda_s2};                // R5
               bitcnt <= bitcnt + 4'h1;
            end
            S_RDAT:
               bitcnt <= bitcnt + 4'h1;
            S_MACK:
               if (sda_s2)
                  st <= S_IDLE;
            default:
               st <= st;
         endcase
      end
      else if (scl_fall)
      begin
         case (st)
            S_ADDR:
               if (bitcnt == 4'h8)
               begin
                  if (sh[7:1] == DMC_ID_ADDR || sh[7:1] == DMC_DIAG_ADDR) // R1 R2
                  begin
                     map_diag <= sh[1];
                     rw       <= sh[0];
                     sel_ok   <= 1'b1;
                     sda_oe_n <= 1'b0;                     // R7
                     st       <= S_AACK;
                  end
                  else
                     st <= S_IDLE;                         // R18
               end
            S_AACK:
               if (rw)
               begin
                  tx       <= rd_byte(map_diag, ptr);      // R9
                  sda_oe_n <= rd_byte(map_diag, ptr) >> 7 != 8'h00;
                  bitcnt   <= 4'h0;
                  st       <= S_RDAT;
               end
               else
               begin
                  sda_oe_n <= 1'b1;
                  bitcnt   <= 4'h0;
                  st       <= S_WADR;
               end
            S_WADR:
               if (bitcnt == 4'h8)
               begin
                  ptr      <= sh;
                  sda_oe_n <= 1'b0;
                  st       <= S_WACK;
               end
            S_WDAT:
               if (bitcnt == 4'h8)
               begin
                  ptr      <= ptr + 8'h01;                 // R17
                  sda_oe_n <= 1'b0;
                  st       <= S_DACK;
               end
            S_WACK, S_DACK:
            begin
               sda_oe_n <= 1'b1;
               bitcnt   <= 4'h0;
               st       <= S_WDAT;
            end
            S_RDAT:
               if (bitcnt == 4'h8)
               begin
                  sda_oe_n <= 1'b1;
                  ptr      <= ptr + 8'h01;                 // R17
                  st       <= S_MACK;
               end
               else
               begin
                  tx       <= {tx[6:0], 1'b0};
                  sda_oe_n <= tx[6];                       // R6
               end
            S_MACK:
            begin
               tx       <= rd_byte(map_diag, ptr);         // R9
               sda_oe_n <= rd_byte(map_diag, ptr) >> 7 != 8'h00;
               bitcnt   <= 4'h0;
               st       <= S_RDAT;
            end
            default:
               st <= S_IDLE;
         endcase
      end

   // open drain: only ever pulls low
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         sda_out <= 1'b0;
      else
         sda_out <= 1'b0;

   // map storage; host writes land only in unprotected bytes
   always_ff @(posedge pclk)
   begin
      if (scl_fall && !start_c && !stop_c && st == S_WDAT && bitcnt == 4'h8
          && wr_ok(map_diag, ptr, wp_id))                  // R5
      begin
         if (map_diag)
            diag_mem[ptr] <= sh;
         else
            id_mem[ptr] <= sh;
      end
      if (apb_wr && paddr == DMC_REG_IDWR)
         id_mem[pwdata[15:8]] <= pwdata[7:0];              // R3
   end

   // calibration and range check, one per channel
   genvar g;
   generate
      for (g = 0; g < DMC_NCH; g++)
      begin : ch
         localparam logic [7:0] B = 8'(g) * DMC_THR_STRIDE;
         logic [15:0] a_hi, a_lo, w_hi, w_lo;
         assign a_hi = {diag_mem[B],         diag_mem[B + 8'h01]};
         assign a_lo = {diag_mem[B + 8'h02], diag_mem[B + 8'h03]};
         assign w_hi = {diag_mem[B + 8'h04], diag_mem[B + 8'h05]};
         assign w_lo = {diag_mem[B + 8'h06], diag_mem[B + 8'h07]};
         always_ff @(posedge pclk or negedge presetn)
            if (!presetn)
            begin
               live[g] <= 16'h0000;
               flg[g]  <= 4'h0;
            end
            else
            begin
               live[g] <= raw[g] + offs[g];                // R12
               flg[g]  <= {live[g] > a_hi, live[g] < a_lo,
                           live[g] > w_hi, live[g] < w_lo}; // R11
            end
      end
   endgenerate

   assign alm = {flg[0][3:2], flg[1][3:2], flg[2][3:2], flg[3][3:2], flg[4][3:2]};
   assign wrn = {flg[0][1:0], flg[1][1:0], flg[2][1:0], flg[3][1:0], flg[4][1:0]};

   // status pins; the 10 us laser budget is met in three cycles
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         laser_on           <= 1'b0;
         signal_lost_output <= 1'b1;
         laser_fault_output <= 1'b0;
      end
      else
      begin
         laser_on           <= !laser_off_input_s2;                   // R14 R15
         signal_lost_output <= !sig_s2;                    // R13
         laser_fault_output <= flg[DMC_CH_BIAS][3] | flg[DMC_CH_TXP][3]; // R16
      end

   // apb slave: one wait state so read data is registered
   assign apb_do = psel & penable & pready;
   assign apb_wr = apb_do & pwrite;
   assign apb_rd = apb_do & !pwrite;

   assign ev[DMC_EV_ALARM]  = |alm;
   assign ev[DMC_EV_WARN]   = |wrn;
   assign ev[DMC_EV_LOS]    = signal_lost_output;
   assign ev[DMC_EV_FAULT]  = laser_fault_output;
   assign ev[DMC_EV_HOSTWR] = st == S_DACK;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel & penable & !pready;
         pslverr <= 1'b0;
         if (psel && penable && !pready)
         begin
            prdata <= 32'h0000_0000;
            if (paddr == DMC_REG_CTRL)
               prdata <= {31'h0, wp_id};
            else if (paddr == DMC_REG_STAT)
               prdata <= {27'h0, status};
            else if (paddr == DMC_REG_MASK)
               prdata <= {27'h0, mask};
            else if (paddr >= DMC_REG_OFFS0 && paddr <= DMC_REG_OFFS4 && paddr[1:0] == 2'h0)
               prdata <= {16'h0, offs[3'(paddr[7:2] - 6'h04)]};
            else if (paddr == DMC_REG_FLAGS)
               prdata <= {6'h0, wrn, 6'h0, alm};
            else if (paddr != DMC_REG_IDWR)
               pslverr <= 1'b1;
         end
      end

   // control registers; offsets reset to zero so samples pass uncorrected
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         wp_id <= DMC_CTRL_RST[0];
         mask  <= DMC_MASK_RST;
         for (int i = 0; i < DMC_NCH; i++)
            offs[i] <= 16'h0000;
      end
      else if (apb_wr)
      begin
         if (paddr == DMC_REG_CTRL)
            wp_id <= pwdata[DMC_CTRL_WP_ID];
         if (paddr == DMC_REG_MASK)
            mask <= pwdata[DMC_NEV-1:0];
         if (paddr >= DMC_REG_OFFS0 && paddr <= DMC_REG_OFFS4 && paddr[1:0] == 2'h0)
            offs[3'(paddr[7:2] - 6'h04)] <= pwdata[15:0];  // R12
      end

   // sticky events on rising level; a new event beats the read clear
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ev_d   <= 5'h00;
         status <= 5'h00;
         irq    <= 1'b0;
      end
      else
      begin
         ev_d   <= ev;
         status <= (status & ~((apb_rd && paddr == DMC_REG_STAT) ? 5'h1F : 5'h00))
                   | (ev & ~ev_d);
         irq    <= |(status & mask);
      end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   laser_shut_a: assert property ($rose(laser_off_input) |-> ##[1:250] !laser_on) // R14
      else $error("laser not off in time");
   laser_follow_a: assert property (laser_on |-> !$past(laser_off_input, 3)) // R15
      else $error("laser on while disabled");
   // the pin chain needs three clean edges after reset before it follows the input
   los_follow_a: assert property ($past(presetn, 3)
      |-> signal_lost_output == !$past(rx_signal_present, 3)) // R13
      else $error("loss of signal output wrong");
   // split in two: thresholds are not reset, so the flags are unknown until loaded
   fault_pin_a: assert property (laser_fault_output
      |-> $past(flg[DMC_CH_BIAS][3] | flg[DMC_CH_TXP][3])) // R16
      else $error("fault output without alarm");
   fault_set_a: assert property ($past(flg[DMC_CH_BIAS][3] | flg[DMC_CH_TXP][3])
      |-> laser_fault_output) // R16
      else $error("fault output missing");
   no_foreign_a: assert property (!sda_oe_n |-> sel_ok) // R18
      else $error("data line driven when not selected");
   sda_on_fall_a: assert property ($changed(sda_oe_n) |-> $past(scl_fall | start_c | stop_c)) // R6
      else $error("data changed off the falling edge");
   shift_on_rise_a: assert property ($changed(sh) |-> $past(scl_rise)) // R5
      else $error("data sampled off the rising edge");
   ptr_step_a: assert property (st == S_RDAT && scl_fall && !start_c && !stop_c
      && bitcnt == 4'h8 |=> ptr == $past(ptr) + 8'h01) // R17
      else $error("pointer did not advance");
   id_match_a: assert property (st == S_ADDR && scl_fall && !start_c && !stop_c
      && bitcnt == 4'h8 && sh[7:1] == DMC_ID_ADDR |=> st == S_AACK && !map_diag) // R1
      else $error("id address not acknowledged");
   diag_match_a: assert property (st == S_ADDR && scl_fall && !start_c && !stop_c
      && bitcnt == 4'h8 && sh[7:1] == DMC_DIAG_ADDR |=> st == S_AACK && map_diag) // R2
      else $error("diag address not acknowledged");
   live_cal_a: assert property (presetn |=> live[0] == 16'($past(raw[0]) + $past(offs[0]))) // R12
      else $error("calibrated value stale");
   irq_level_a: assert property (##1 irq == |($past(status) & $past(mask)))
      else $error("interrupt level wrong");

   read_cov: cover property (st == S_MACK ##[1:400] st == S_RDAT);
   write_cov: cover property (st == S_DACK ##[1:400] st == S_WDAT);
   fault_cov: cover property ($rose(laser_fault_output));
   irq_cov: cover property ($rose(irq));

endmodule
`default_nettype wire

// [include/dmc_pkg.sv]
// constants and types for the optical module management link
// assumes a single pclk domain; serial link pins are sampled, not clocked on
package dmc_pkg;

   // two-wire device addresses (seven bits)
   localparam logic [6:0] DMC_ID_ADDR    = 7'h50;
   localparam logic [6:0] DMC_DIAG_ADDR  = 7'h51;

   // diagnostics map layout
   localparam int         DMC_NCH        = 5;
   localparam logic [7:0] DMC_THR_STRIDE = 8'h08;
   localparam logic [7:0] DMC_LIVE_BASE  = 8'h60;
   localparam logic [7:0] DMC_LIVE_TOP   = 8'h7F;
   localparam logic [7:0] DMC_ALM_BYTE0  = 8'h70;
   localparam logic [7:0] DMC_ALM_BYTE1  = 8'h71;
   localparam logic [7:0] DMC_WRN_BYTE0  = 8'h74;
   localparam logic [7:0] DMC_WRN_BYTE1  = 8'h75;

   // channel order in the live block
   localparam int         DMC_CH_BIAS    = 2;
   localparam int         DMC_CH_TXP     = 3;

   // apb register byte offsets
   localparam logic [7:0] DMC_REG_CTRL   = 8'h00;
   localparam logic [7:0] DMC_REG_STAT   = 8'h04;
   localparam logic [7:0] DMC_REG_MASK   = 8'h08;
   localparam logic [7:0] DMC_REG_OFFS0  = 8'h10;
   localparam logic [7:0] DMC_REG_OFFS4  = 8'h20;
   localparam logic [7:0] DMC_REG_IDWR   = 8'h24;
   localparam logic [7:0] DMC_REG_FLAGS  = 8'h28;

   // field positions and reset values
   localparam int         DMC_CTRL_WP_ID = 0;
   localparam int         DMC_NEV        = 5;
   localparam logic [0:0] DMC_CTRL_RST   = 1'h1;
   localparam logic [4:0] DMC_MASK_RST   = 5'h00;
   localparam int         DMC_EV_ALARM   = 0;
   localparam int         DMC_EV_WARN    = 1;
   localparam int         DMC_EV_LOS     = 2;
   localparam int         DMC_EV_FAULT   = 3;
   localparam int         DMC_EV_HOSTWR  = 4;

   // laser shut-off budget
   localparam int         DMC_CLK_NS        = 40;
   localparam int         DMC_TXDIS_MAX_NS  = 10000;
   localparam int         DMC_TXDIS_MAX_CYC = DMC_TXDIS_MAX_NS / DMC_CLK_NS;

   // raw monitor samples: temp, vcc, bias, tx power, rx power
   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] vcc;
      logic [15:0] bias;
      logic [15:0] txp;
      logic [15:0] rxp;
   } dmc_mon_t;

endpackage
